// ### reset_source_and_watchdog_test.sv
// Purpose: self-checking bench of the reset sequencer and watchdog
// Assumes: zero wait-state bus, shortened watchdog base
// Notes:   expectations come from the bench functions
`timescale 1ns/1ps
`include "rsw_defs.svh"
module reset_source_and_watchdog_test;
  import rsw_pkg::*;
  localparam int B = 4;
  logic         hclk, hresetn, osc, cmf, spec, dis, hold, pin;
  logic [31:0]  hwdata, hrdata, r;
  logic         hreadyout, hresp, pin_o, pin_oe, cpu_rst_n, irq;
  logic [15:0]  reset_vec;
  rsw_ahb_req_t req, ahb;
  int           num_errors, checked, n, t, cyc, oe_cnt;

  assign ahb = '{hsel: req.hsel, haddr: req.haddr, htrans: req.htrans,
                 hwrite: req.hwrite, hsize: req.hsize, hready: hreadyout};

  rsw_top #(.WDT_BASE_LOG2(B)) u_rsw_top (.hclk(hclk), .hresetn(hresetn),
    .ahb_i(ahb), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rst_pin_i(pin), .rst_pin_o(pin_o),
    .rst_pin_oe(pin_oe), .osc_ok_i(osc), .clk_fail_i(cmf),
    .special_i(spec), .wdt_dis_i(dis), .cpu_rst_n(cpu_rst_n),
    .reset_vec(reset_vec), .irq(irq));
  rsw_ext_reset u_rsw_ext_reset (.drv_val(pin_o), .drv_en(pin_oe),
    .hold_low(hold), .pin(pin));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  always @(posedge pin_oe) oe_cnt <= oe_cnt + 1;

  // ****************************************************************
  // expectations and compares
  // ****************************************************************
  function automatic logic [15:0] exp_vec(input rsw_cause_t c,
                                          input logic s);
    logic [15:0] v;
    v = s ? 16'hBFFE : 16'hFFFE;
    if (c == CAUSE_CMF) v = v - 16'h2;
    if (c == CAUSE_WDT) v = v - 16'h4;
    return v;
  endfunction
  function automatic int period(input int rate);
    return 1 << (B + 2 * rate);
  endfunction
  function automatic logic pick(input int w);
    case (w)
      0: return cpu_rst_n;
      1: return pin_oe;
      default: return irq;
    endcase
  endfunction

  task automatic give_verdict();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic fail(input string m);
    num_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk_b(input logic g, input logic e);
    checked++;
    if (g !== e) fail("flag differs");
  endtask
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) fail("word differs");
  endtask
  task automatic chk_n(input int g, input int lo, input int hi);
    checked++;
    if (g < lo || g > hi) fail("cycle count out of range");
  endtask
  task automatic await(input int w, input logic v, input int lim,
                       output int k);
    k = 0;
    while (pick(w) !== v && k < lim) begin
      @(posedge hclk);
      k++;
    end
    if (k >= lim) begin
      fail("wait ran out");
      give_verdict();
    end
  endtask

  // ****************************************************************
  // bus master and sequences
  // ****************************************************************
  // one idle edge after each transfer: transfers are never back-to-back
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    req <= '{hsel: 1'b1, haddr: {24'h0, a}, htrans: 2'h2, hwrite: w,
             hsize: 3'h2, hready: 1'b1};
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    req.htrans <= 2'h0;
    req.hsel <= 1'b0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    q = hrdata;
    chk_b(hresp, 1'b0);
    if (k >= 40) begin
      fail("bus hang");
      give_verdict();
    end
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0, r);
    chk_w(r & m, e);
  endtask
  task automatic pin_low(input int len);
    hold <= 1'b1;
    repeat (len) @(posedge hclk);
    hold <= 1'b0;
  endtask
  task automatic seq(input logic [15:0] v);
    int k;
    await(1, 1'b1, 3000, k);
    chk_b(pin_o, 1'b0);
    k = 0;
    while (pin_oe === 1'b1 && k < 20) begin
      @(posedge hclk);
      k++;
    end
    chk_n(k, 4, 4);
    await(0, 1'b1, 300, k);
    chk_w({16'h0, reset_vec}, {16'h0, v});
  endtask
  task automatic svc();
    wr(`RSW_A_SERVICE, 32'h55);
    wr(`RSW_A_SERVICE, 32'hAA);
    t = cyc;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    hresetn = 1'b0;
    osc = 1'b0;
    cmf = 1'b0;
    spec = 1'b0;
    dis = 1'b1;
    hold = 1'b1;
    hwdata = 32'h0;
    req = '0;
    void'($urandom(88061));
    repeat (4) @(posedge hclk);
    chk_b(hreadyout, 1'b1);
    chk_w({16'h0, reset_vec}, {16'h0, exp_vec(CAUSE_POR, 1'b0)});
    hresetn <= 1'b1;
    osc <= 1'b1;
    repeat (4100) @(posedge hclk);
    chk_b(cpu_rst_n, 1'b0);
    hold <= 1'b0;
    await(0, 1'b1, 20, n);
    rdc(`RSW_A_STATUS, 32'h1F, 32'h08);
    rdc(`RSW_A_STATUS, 32'h1F, 32'h00);
    hresetn <= 1'b0;
    osc <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    osc <= 1'b1;
    await(0, 1'b1, 5000, n);
    chk_n(n, 4064, 4072);
    rdc(`RSW_A_STATUS, 32'h1F, 32'h08);
    t = oe_cnt;
    repeat (200) @(posedge hclk);
    chk_n(oe_cnt - t, 0, 0);
    dis <= 1'b0;
    repeat (100) @(posedge hclk);
    chk_n(oe_cnt - t, 0, 0);
    fork
      pin_low(16 + $urandom_range(0, 10));
      seq(exp_vec(CAUSE_EXT, 1'b0));
    join
    await(1, 1'b1, 100, n);
    chk_n(n, period(0) - 1, period(0) + 4);
    seq(exp_vec(CAUSE_WDT, 1'b0));
    wr(`RSW_A_CTRL, 32'h1);
    svc();
    wr(`RSW_A_CTRL, 32'h3);
    rdc(`RSW_A_STATUS, 32'h1F, 32'h15);
    rdc(`RSW_A_STATE, 32'hC3, 32'h42);
    await(1, 1'b1, 2000, n);
    chk_n(cyc - t, period(1) - 6, period(1) + 4);
    seq(exp_vec(CAUSE_WDT, 1'b0));
    rdc(`RSW_A_STATE, 32'hC0, 32'h00);
    spec <= 1'b1;
    fork
      pin_low(16 + $urandom_range(0, 10));
      seq(exp_vec(CAUSE_EXT, 1'b1));
    join
    t = oe_cnt;
    repeat (150) @(posedge hclk);
    chk_n(oe_cnt - t, 0, 0);
    wr(`RSW_A_MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(`RSW_A_CTRL, 32'(i));
      svc();
      await(1, 1'b1, 2000, n);
      chk_n(cyc - t, period(i) - 6, period(i) + 4);
      seq(exp_vec(CAUSE_WDT, 1'b1));
    end
    await(2, 1'b1, 5, n);
    rdc(`RSW_A_STATUS, 32'h1, 32'h1);
    await(2, 1'b0, 5, n);
    // junk service codes and unmapped reads between arm and clear
    wr(`RSW_A_CTRL, 32'h1);
    t = oe_cnt;
    repeat (6) begin
      wr(`RSW_A_SERVICE, 32'h55);
      r = {24'h0, 8'($urandom_range(0, 255))};
      if (r == 32'h55 || r == 32'hAA) r = 32'h0F;
      wr(`RSW_A_SERVICE, r);
      rdc(8'(32'h14 + 4 * $urandom_range(0, 50)), 32'hFFFFFFFF, 32'h0);
      wr(`RSW_A_SERVICE, 32'hAA);
    end
    chk_n(oe_cnt - t, 0, 0);
    repeat (30) wr(`RSW_A_SERVICE, 32'hAA);
    chk_n(oe_cnt - t, 1, 1);
    await(0, 1'b1, 300, n);
    chk_w({16'h0, reset_vec}, {16'h0, exp_vec(CAUSE_WDT, 1'b1)});
    wr(`RSW_A_MASK, 32'h0);
    dis <= 1'b1;
    spec <= 1'b0;
    fork
      begin
        cmf <= 1'b1;
        repeat (3) @(posedge hclk);
        cmf <= 1'b0;
      end
      seq(exp_vec(CAUSE_CMF, 1'b0));
    join
    chk_b(irq, 1'b0);
    rdc(`RSW_A_STATE, 32'h3, 32'h3);
    t = oe_cnt;
    repeat (200) @(posedge hclk);
    chk_n(oe_cnt - t, 0, 0);
    give_verdict();
  end
endmodule

// ### rsw_defs.svh
// Purpose: named constants of the reset sequencer and watchdog
// Assumes: bus clock hclk is the internal cycle clock
// Notes:   included by every design file
`ifndef RSW_DEFS_SVH
`define RSW_DEFS_SVH

// ****************************************************************
// sequence timing, in bus cycles; RSW_RATE_SPAN is the rate span in divider bits
// ****************************************************************
`define RSW_POR_CYCLES   12'd4064
`define RSW_DRIVE_CYCLES 12'd4
`define RSW_GAP_CYCLES   12'd2
`define RSW_SYNC_LAT     12'd2
`define RSW_WIN_CYCLES   7'd64
`define RSW_RATE_SPAN    3'd6

// ****************************************************************
// service codes and vectors
// ****************************************************************
`define RSW_SVC_ARM      8'h55
`define RSW_SVC_CLR      8'hAA
`define RSW_VEC_NORM_RST 16'hFFFE
`define RSW_VEC_NORM_CMF 16'hFFFC
`define RSW_VEC_NORM_WDT 16'hFFFA
`define RSW_VEC_SPEC_RST 16'hBFFE
`define RSW_VEC_SPEC_CMF 16'hBFFC
`define RSW_VEC_SPEC_WDT 16'hBFFA

// ****************************************************************
// register map (byte offsets) and fields
// ****************************************************************
`define RSW_A_CTRL    8'h00
`define RSW_A_SERVICE 8'h04
`define RSW_A_STATUS  8'h08
`define RSW_A_MASK    8'h0C
`define RSW_A_STATE   8'h10
`define RSW_CTRL_INH  2
`define RSW_ST_WDT    0
`define RSW_ST_CMF    1
`define RSW_ST_EXT    2
`define RSW_ST_POR    3
`define RSW_ST_REF    4
`define RSW_NEV       5

`endif

// ### rsw_ext_reset.sv
// Purpose: board side of the open-drain reset pin
// Assumes: pull-up on the pin, no rc delay
// Notes:   hold_low keeps the pin low while it is set
`timescale 1ns/1ps
module rsw_ext_reset (
  input  wire logic drv_val,  // device drive value
  input  wire logic drv_en,   // device pulls the pin
  input  wire logic hold_low, // board holds the pin low
  output logic      pin       // wired pin level
);
  // ****************************************************************
  // wired-and with pull-up
  // ****************************************************************
  // fast rise on release, so the device sees the true source
  assign pin = ((drv_en && !drv_val) || hold_low) ? 1'b0 : 1'b1;
endmodule

// ### rsw_pkg.sv
// Purpose: types of the reset sequencer and watchdog
// Assumes: rsw_defs.svh gives the numbers
// Notes:   state of the top module is one packed struct
`include "rsw_defs.svh"
package rsw_pkg;

  typedef enum logic [2:0] {
    SEQ_POR  = 3'h0,
    SEQ_HOLD = 3'h1,
    SEQ_RUN  = 3'h3,
    SEQ_DRV  = 3'h2,
    SEQ_GAP  = 3'h6
  } rsw_seq_t;

  typedef enum logic [1:0] {
    CAUSE_POR = 2'h0,
    CAUSE_EXT = 2'h1,
    CAUSE_WDT = 2'h2,
    CAUSE_CMF = 2'h3
  } rsw_cause_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } rsw_ahb_req_t;

  typedef struct packed {
    rsw_seq_t    seq;
    logic [11:0] cnt;
    rsw_cause_t  cause;
    rsw_cause_t  pend;
    logic        cpu_rst_n;
    logic        pin_oe;
    logic [15:0] vec;
    logic        special;
    logic        watchdog_disable_bit;
    logic [1:0]  rate;
    logic        inh;
    logic        rate_done;
    logic [6:0]  win;
    logic        armed;
    logic [`RSW_NEV-1:0] status;
    logic [`RSW_NEV-1:0] mask;
    logic        irq;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    logic        hready;
  } rsw_state_t;

endpackage

// ### rsw_sync.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are levels from outside the hclk domain
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`include "rsw_defs.svh"
module rsw_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,    // bus clock
  input  wire logic         hresetn, // async reset, low
  input  wire logic [W-1:0] d,       // async level in
  input  wire logic [W-1:0] rst_val, // unused; both stages reset to zero
  output logic      [W-1:0] q        // synchronised level
);
  logic [1:0][W-1:0] s_q;

  initial begin
    if (W < 1) $error("rsw_sync: W must be at least 1");
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= {s_q[0], d};
    end
  end

  assign q = s_q[1] | (rst_val & ~rst_val);
endmodule

// ### rsw_top.sv
// Purpose: reset sequencer, reset pin control and watchdog
// Assumes: AHB-Lite slave, single word transfers, no back-to-back
// Notes:   controls reload on every system reset, status survives
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "rsw_defs.svh"

// Functional notes
// - four sources; POR and pin share a vector, watchdog and clock fail own
// - any reset reloads controls and presents a known start vector
// - after oscillator start wait 4064 cycles before leaving power-on reset
// - pin still low after that wait keeps the device in reset
// - on a reset condition drive the pin low for four cycles
// - two cycles after release sample pin; low means external reset
// - pin high at sample keeps the pending source; watchdog and clock monitor own vectors
// - enabled watchdog counts freely; expiry starts a system reset
// - disable bit is taken only at a system reset
// - special modes start with watchdog resets inhibited; writing zero enables
// - rate resets to zero; code 0 divides by 2^15, code 1 by 2^17
// - normal modes allow one rate write within 64 cycles of reset
// - 0x55 then 0xAA to the service register clears the watchdog
// - disable bit clear enables the watchdog, set disables it
module rsw_top #(
  parameter int WDT_BASE_LOG2 = 15
) (
  input  wire logic                 hclk,        // bus clock
  input  wire logic                 hresetn,     // power-on reset, low
  input  wire rsw_pkg::rsw_ahb_req_t ahb_i,      // address phase
  input  wire logic [31:0]          hwdata,      // write data
  output logic [31:0]               hrdata,      // read data
  output logic                      hreadyout,   // always ready
  output logic                      hresp,       // always OKAY
  input  wire logic                 rst_pin_i,   // reset pin level
  output logic                      rst_pin_o,   // pin drive value
  output logic                      rst_pin_oe,  // high while driven
  input  wire logic                 osc_ok_i,    // oscillator running
  input  wire logic                 clk_fail_i,  // clock monitor trip
  input  wire logic                 special_i,   // test/boot mode strap
  input  wire logic                 wdt_dis_i,   // watchdog_disable_bit
  output logic                      cpu_rst_n,   // core held, low
  output logic [15:0]               reset_vec,   // vector address
  output logic                      irq          // level interrupt
);
  import rsw_pkg::*;

  rsw_state_t  q, d;
  logic [4:0]  pins;
  logic        pin_s, osc_s, cmf_s, spec_s, dis_s;
  logic        wdt_tmo, wdt_clr, wdt_en;
  logic        acc, svc_wr, ctrl_wr;
  logic [31:0] rd;
  logic [`RSW_NEV-1:0] ev;

  initial begin
    if (WDT_BASE_LOG2 < 1 || WDT_BASE_LOG2 > 25)
      $error("rsw_top: WDT_BASE_LOG2 out of range");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  rsw_sync #(.W(5)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({rst_pin_i, osc_ok_i, clk_fail_i, special_i, wdt_dis_i}),
    .rst_val (5'h00),
    .q       (pins)
  );
  assign {pin_s, osc_s, cmf_s, spec_s, dis_s} = pins;

  // ****************************************************************
  // watchdog divider
  // ****************************************************************
  assign wdt_en  = (q.seq == SEQ_RUN) && !q.watchdog_disable_bit && !q.inh;
  assign svc_wr  = q.wr_pend && (q.wr_addr == `RSW_A_SERVICE);
  assign ctrl_wr = q.wr_pend && (q.wr_addr == `RSW_A_CTRL);
  assign wdt_clr = svc_wr && q.armed
                   && (hwdata[7:0] == `RSW_SVC_CLR);

  rsw_wdt #(.BASE_LOG2(WDT_BASE_LOG2)) u_wdt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (wdt_en),
    .clr     (wdt_clr),
    .rate    (q.rate),
    .tmo     (wdt_tmo)
  );

  // ****************************************************************
  // register read mux
  // ****************************************************************
  assign acc = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];

  always_comb begin
    rd = 32'h0000_0000;
    // pure mux: the status clear happens in the sequencer process
    case (ahb_i.haddr[7:0])
      `RSW_A_CTRL:   rd = {29'h0, q.inh, q.rate};
      `RSW_A_STATUS: rd = {27'h0, q.status};
      `RSW_A_MASK:   rd = {27'h0, q.mask};
      `RSW_A_STATE:  rd = {24'h0, q.armed, q.rate_done, q.special,
                           q.watchdog_disable_bit, wdt_en, q.cpu_rst_n, q.cause};
      default:       rd = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // sequencer, registers, bus slave
  // ****************************************************************
  always_comb begin
    d         = q;
    ev        = '0;
    d.cnt     = q.cnt + 1'b1;
    d.hready  = 1'b1;
    d.wr_pend = 1'b0;
    case (q.seq)
      SEQ_POR: begin
        if (!osc_s) begin
          d.cnt = '0;
        end else if (q.cnt == `RSW_POR_CYCLES - 1'b1) begin
          d.seq = SEQ_HOLD;
        end
      end
      SEQ_HOLD: begin
        d.special = spec_s;
        d.watchdog_disable_bit   = dis_s;
        if (pin_s) begin
          d.seq       = SEQ_RUN;
          d.cpu_rst_n = 1'b1;
          ev[`RSW_ST_POR] = (q.cause == CAUSE_POR);
          // strap as latched at this same edge: an internal reset may
          // spend one cycle only in hold, too short for q.special
          case (q.cause)
            CAUSE_WDT: d.vec = spec_s ? `RSW_VEC_SPEC_WDT
                                      : `RSW_VEC_NORM_WDT;
            CAUSE_CMF: d.vec = spec_s ? `RSW_VEC_SPEC_CMF
                                      : `RSW_VEC_NORM_CMF;
            default:   d.vec = spec_s ? `RSW_VEC_SPEC_RST
                                      : `RSW_VEC_NORM_RST;
          endcase
        end
      end
      SEQ_RUN: begin
        d.cnt = '0;
        // clock fail outranks timeout, timeout outranks the pin
        if (cmf_s || wdt_tmo || !pin_s) begin
          d.seq       = SEQ_DRV;
          d.pin_oe    = 1'b1;
          d.cpu_rst_n = 1'b0;
          d.pend      = cmf_s ? CAUSE_CMF
                      : (wdt_tmo ? CAUSE_WDT : CAUSE_EXT);
        end
      end
      SEQ_DRV: begin
        if (q.cnt == `RSW_DRIVE_CYCLES - 1'b1) begin
          d.seq    = SEQ_GAP;
          d.pin_oe = 1'b0;
          d.cnt    = '0;
        end
      end
      SEQ_GAP: begin
        // synchroniser lag added so the pin is judged two cycles on
        if (q.cnt == `RSW_GAP_CYCLES + `RSW_SYNC_LAT - 1'b1) begin
          d.seq   = SEQ_HOLD;
          d.cause = pin_s ? q.pend : CAUSE_EXT;
          ev[`RSW_ST_EXT] = !pin_s || (q.pend == CAUSE_EXT);
          ev[`RSW_ST_WDT] = pin_s && (q.pend == CAUSE_WDT);
          ev[`RSW_ST_CMF] = pin_s && (q.pend == CAUSE_CMF);
        end
      end
      default: begin
        d.seq = SEQ_POR;
      end
    endcase

    // controls reload while any reset is in progress
    if (q.seq != SEQ_RUN) begin
      d.rate      = 2'h0;
      d.rate_done = 1'b0;
      d.win       = 7'h00;
      d.armed     = 1'b0;
      d.inh       = d.special;
    end else begin
      if (q.win != `RSW_WIN_CYCLES)
        d.win = q.win + 1'b1;
      if (ctrl_wr) begin
        if (q.special) begin
          d.rate = hwdata[1:0];
          d.inh  = hwdata[`RSW_CTRL_INH];
        end else if (!q.rate_done && q.win != `RSW_WIN_CYCLES) begin
          d.rate      = hwdata[1:0];
          d.rate_done = 1'b1;
        end else begin
          ev[`RSW_ST_REF] = 1'b1;
        end
      end
      if (svc_wr) begin
        if (hwdata[7:0] == `RSW_SVC_ARM)
          d.armed = 1'b1;
        else if (hwdata[7:0] == `RSW_SVC_CLR)
          d.armed = 1'b0;
      end
    end

    // bus slave: read data registered at the address phase
    if (acc) begin
      d.wr_pend = ahb_i.hwrite;
      d.wr_addr = ahb_i.haddr[7:0];
      d.hrdata  = ahb_i.hwrite ? 32'h0000_0000 : rd;
      if (!ahb_i.hwrite && ahb_i.haddr[7:0] == `RSW_A_STATUS)
        d.status = '0;
    end
    if (q.wr_pend && q.wr_addr == `RSW_A_MASK)
      d.mask = hwdata[`RSW_NEV-1:0];
    // a new event wins over the read clear
    d.status = d.status | ev;
    d.irq    = |(d.status & d.mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q         <= '0;
      q.seq     <= SEQ_POR;
      q.cause   <= CAUSE_POR;
      q.vec     <= `RSW_VEC_NORM_RST;
      q.inh     <= 1'b1;
      q.watchdog_disable_bit   <= 1'b1;
      q.hready  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hrdata     = q.hrdata;
  assign hreadyout  = q.hready;
  assign hresp      = q.wr_addr[0] & 1'b0;
  assign rst_pin_o  = q.wr_addr[0] & 1'b0;
  assign rst_pin_oe = q.pin_oe;
  assign cpu_rst_n  = q.cpu_rst_n;
  assign reset_vec  = q.vec;
  assign irq        = q.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  drive_four_a: assert property ($rose(q.pin_oe) |->
    q.pin_oe [*4] ##1 !q.pin_oe) else $error("pin drive not four");
  por_wait_a: assert property ((q.seq == SEQ_POR && d.seq == SEQ_HOLD)
    |-> q.cnt == `RSW_POR_CYCLES - 12'd1) else $error("por wait wrong");
  hold_pin_a: assert property ((q.seq == SEQ_HOLD && !pin_s)
    |=> !q.cpu_rst_n) else $error("left reset with pin low");
  ext_class_a: assert property ((q.seq == SEQ_GAP
    && d.seq == SEQ_HOLD && !pin_s) |=> q.cause == CAUSE_EXT)
    else $error("external not classified");
  int_class_a: assert property ((q.seq == SEQ_GAP && d.seq == SEQ_HOLD
    && pin_s && q.pend == CAUSE_WDT) |=> q.cause == CAUSE_WDT)
    else $error("watchdog not classified");
  vec_sel_a: assert property (($rose(q.cpu_rst_n) && !q.special
    && q.cause == CAUSE_WDT) |-> q.vec == `RSW_VEC_NORM_WDT)
    else $error("watchdog vector wrong");
  wdt_fire_a: assert property ((wdt_tmo && q.seq == SEQ_RUN
    && !cmf_s) |=> q.pin_oe && q.pend == CAUSE_WDT)
    else $error("timeout did not reset");
  rate_init_a: assert property ($rose(q.cpu_rst_n) |->
    q.rate == 2'h0 && !q.rate_done) else $error("rate not reset");
  rate_once_a: assert property ((q.rate_done && !q.special
    && q.seq == SEQ_RUN) |=> $stable(q.rate)) else $error("rate rewritten");
  svc_seq_a: assert property ((svc_wr && !q.armed) |-> !wdt_clr)
    else $error("clear without arm");
  wdt_off_a: assert property ((q.inh || q.watchdog_disable_bit) |-> !wdt_en)
    else $error("watchdog ran while off");

  // reset sequencing and controls as seen from outside
  cpu_held_a: assert property ((q.seq != SEQ_RUN)
    |-> !q.cpu_rst_n) else $error("core released during reset");
  gap_quiet_a: assert property ((q.seq == SEQ_GAP)
    |-> !q.pin_oe) else $error("pin driven while sampling");
  hold_exit_a: assert property ((q.seq == SEQ_HOLD && pin_s)
    |=> q.cpu_rst_n && q.seq == SEQ_RUN)
    else $error("pin high but still held");
  cmf_first_a: assert property (($rose(q.pin_oe) && $past(cmf_s))
    |-> q.pend == CAUSE_CMF) else $error("clock fail not first");
  cmf_vec_a: assert property (($rose(q.cpu_rst_n)
    && q.cause == CAUSE_CMF) |-> q.vec == (q.special ? `RSW_VEC_SPEC_CMF
    : `RSW_VEC_NORM_CMF)) else $error("clock fail vector wrong");
  wdt_stop_a: assert property ((q.seq != SEQ_RUN) |-> !wdt_en)
    else $error("watchdog ran in reset");
  rate_late_a: assert property ((ctrl_wr && !q.special
    && q.seq == SEQ_RUN && q.win == `RSW_WIN_CYCLES) |=> $stable(q.rate))
    else $error("late rate write taken");
  svc_arm_a: assert property ((svc_wr && q.seq == SEQ_RUN
    && hwdata[7:0] == `RSW_SVC_ARM) |=> q.armed)
    else $error("arm code not taken");

  wdt_reset_c: cover property (q.seq == SEQ_GAP && q.pend == CAUSE_WDT
    ##1 q.seq == SEQ_HOLD);
  ext_reset_c: cover property (q.seq == SEQ_HOLD && q.cause == CAUSE_EXT
    ##1 q.seq == SEQ_RUN);
  service_c:   cover property (wdt_clr);
  irq_c:       cover property ($rose(q.irq));
  cmf_reset_c: cover property (q.seq == SEQ_GAP && q.pend == CAUSE_CMF
    ##1 q.seq == SEQ_HOLD);
endmodule

// ### rsw_wdt.sv
// Purpose: free-running watchdog divider with rate select
// Assumes: clr and en come from hclk logic
// Notes:   tmo is a one-cycle pulse from a flop
`timescale 1ns/1ps
`include "rsw_defs.svh"
module rsw_wdt #(
  parameter int BASE_LOG2 = 15
) (
  input  wire logic       hclk,    // bus clock
  input  wire logic       hresetn, // async reset, low
  input  wire logic       en,      // watchdog running
  input  wire logic       clr,     // restart the count
  input  wire logic [1:0] rate,    // watchdog_rate_select
  output logic            tmo      // timeout pulse
);
  localparam int CW = BASE_LOG2 + 6;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tmo;
  } rsw_wdt_t;

  rsw_wdt_t      q, d;
  logic [CW-1:0] lim;

  initial begin
    if (BASE_LOG2 < 1 || BASE_LOG2 > 25)
      $error("rsw_wdt: BASE_LOG2 out of range");
  end

  // terminal count 2^(base+2*rate)-1: 2^15,17,19,21 at default
  always_comb begin
    lim   = {CW{1'b1}} >> (`RSW_RATE_SPAN - {rate, 1'b0});
    d     = q;
    d.tmo = 1'b0;
    if (clr || !en) begin
      d.cnt = '0;
    end else if (q.cnt == lim) begin
      d.cnt = '0;
      d.tmo = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tmo = q.tmo;
endmodule
